// ### hdl/csf_top.sv
`timescale 1ns/1ps
`default_nettype none
module csf_top
    import csf_pkg::*;
#(
    parameter int unsigned STALE_CYCLES = BLOCK_CYC
) (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              policy_propagate,
    input  wire logic              can_alter_flag,
    input  wire logic              reference_source_generator,
    input  wire logic              local_locked,
    input  wire logic              aux_in_unlocked,
    input  wire logic              rx_strobe,
    input  wire logic              rx_chan,
    input  wire logic              rx_z,
    input  wire csf_sub_t          rx_sub,
    input  wire logic              tx_strobe,
    input  wire logic              tx_chan,
    input  wire logic              tx_z,
    input  wire logic [23:0]       tx_audio,
    input  wire logic              tx_v,
    input  wire logic              tx_u,
    input  wire logic [1:0]        tx_sample_freq,
    input  wire logic [3:0]        tx_mode,
    input  wire logic [3:0]        tx_user_format,
    input  wire logic              rd_chan,
    input  wire logic [4:0]        rd_byte,
    output logic [7:0]             rd_data,
    output var csf_fields_t [1:0]  rx_fields,
    output logic [1:0]             block_done,
    output logic [1:0]             cs_stale,
    output logic                   rx_out_strobe,
    output logic                   rx_out_chan,
    output logic                   rx_non_audio,
    output logic                   rx_user_bit,
    output logic [7:0]             rx_user_index,
    output logic                   rx_parity_err,
    output logic                   tx_out_strobe,
    output logic                   tx_out_z,
    output csf_sub_t               tx_sub,
    output logic [1:0]             unlocked_out,
    output logic                   operator_unsync
);

    logic              rst_s1;
    logic              rst_n;
    logic              z_seen;
    logic [7:0]        rx_idx   [NUM_CHAN];
    logic [7:0]        tx_idx   [NUM_CHAN];
    logic [191:0]      cs_work  [NUM_CHAN];
    logic [191:0]      cs_held  [NUM_CHAN];
    logic [STALE_W-1:0] stale_cnt [NUM_CHAN];
    logic [7:0]        next_rx_idx;
    logic [7:0]        next_tx_idx;
    logic              rx_start;
    logic [1:0]        next_unlocked;
    logic              tx_c;

    // Truncate the derived count to the counter width; higher bits are dropped.
    localparam logic [STALE_W-1:0] STALE_MAX = STALE_W'(STALE_CYCLES - 1);

    // Bit position of a block index, also used by the transmit side.
    function automatic logic [7:0] step_idx(input logic start, input logic [7:0] cur);
        if (start || cur == IDX_LAST) begin
            step_idx = IDX_FIRST;
        end else begin
            step_idx = cur + 8'h01;
        end
    endfunction

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // Channel 1 of a Z frame starts its block too, so remember the Z of channel 0.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            z_seen <= 1'b0;
        end else if (rx_strobe && !rx_chan) begin
            z_seen <= rx_z;
        end
    end

    always_comb begin
        rx_start    = rx_chan ? z_seen : rx_z;
        next_rx_idx = step_idx(rx_start, rx_idx[rx_chan]);
        next_tx_idx = step_idx(tx_chan ? tx_idx[1] == IDX_LAST : tx_z, tx_idx[tx_chan]);
    end

    for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
        // Counter and storage are kept apart per channel.
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                rx_idx[ch] <= IDX_LAST;
            end else if (rx_strobe && rx_chan == ch) begin
                rx_idx[ch] <= next_rx_idx;
            end
        end

        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                cs_work[ch] <= CS_RST;
            end else if (rx_strobe && rx_chan == ch) begin
                cs_work[ch][next_rx_idx] <= rx_sub.c;
            end
        end

        // The last bit goes straight into the held copy, as the work copy is written on the same edge.
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                cs_held[ch] <= CS_RST;
            end else if (rx_strobe && rx_chan == ch && next_rx_idx == IDX_LAST) begin
                cs_held[ch]            <= cs_work[ch];
                cs_held[ch][CS_BITS-1] <= rx_sub.c;
            end
        end

        // One pulse per completed block, on the edge that loads the held copy.
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                block_done[ch] <= 1'b0;
            end else begin
                block_done[ch] <= rx_strobe && rx_chan == ch && next_rx_idx == IDX_LAST;
            end
        end

        // The counter parks at its limit so it never wraps back to fresh.
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                stale_cnt[ch] <= '0;
            end else if (block_done[ch]) begin
                stale_cnt[ch] <= '0;
            end else if (stale_cnt[ch] != STALE_MAX) begin
                stale_cnt[ch] <= stale_cnt[ch] + 1'b1;
            end
        end

        // A block period without a refresh means the channel status is stale.
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                cs_stale[ch] <= 1'b1;
            end else if (block_done[ch]) begin
                cs_stale[ch] <= 1'b0;
            end else if (stale_cnt[ch] == STALE_MAX) begin
                cs_stale[ch] <= 1'b1;
            end
        end

        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                tx_idx[ch] <= IDX_LAST;
            end else if (tx_strobe && tx_chan == ch) begin
                tx_idx[ch] <= next_tx_idx;
            end
        end

        // Only inputs feeding this output count; cs_stale plays no part, so a stale block keeps its held unlock bit.
        always_comb begin
            if (reference_source_generator) begin
                next_unlocked[ch] = 1'b0;
            end else if (!can_alter_flag) begin
                next_unlocked[ch] = cs_held[ch][UNLK_POS] | aux_in_unlocked;
            end else if (policy_propagate) begin
                next_unlocked[ch] = !local_locked | cs_held[ch][UNLK_POS] | aux_in_unlocked;
            end else begin
                next_unlocked[ch] = !local_locked;
            end
        end

        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                unlocked_out[ch] <= UNLK_RST;
            end else begin
                unlocked_out[ch] <= next_unlocked[ch];
            end
        end
    end

    // Decoded fields are plain wiring from the held flops, so they change only as block_done pulses.
    always_comb begin
        for (int ch = 0; ch < NUM_CHAN; ch++) begin
            rx_fields[ch].sample_freq = cs_held[ch][SF_LSB+:2];
            rx_fields[ch].unlocked    = cs_held[ch][UNLK_POS];
            rx_fields[ch].mode        = cs_held[ch][MODE_LSB+:4];
            rx_fields[ch].user_format = cs_held[ch][FMT_LSB+:4];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            operator_unsync <= 1'b0;
        end else begin
            operator_unsync <= !reference_source_generator && !policy_propagate && !local_locked;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else if (rd_byte < 5'(CS_BYTES)) begin
            rd_data <= cs_held[rd_chan][{rd_byte, 3'b000}+:8];
        end else begin
            rd_data <= 8'h00;
        end
    end

    // Strobe and channel tag of each received subframe, one cycle late.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_out_strobe <= 1'b0;
            rx_out_chan   <= 1'b0;
        end else begin
            rx_out_strobe <= rx_strobe;
            if (rx_strobe) begin
                rx_out_chan <= rx_chan;
            end
        end
    end

    // Per-sample flags stand until the next subframe, so no block delay applies to them.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_non_audio <= 1'b0;
            rx_user_bit  <= 1'b0;
        end else if (rx_strobe) begin
            rx_non_audio <= rx_sub.v;
            rx_user_bit  <= rx_sub.u;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_user_index <= 8'h00;
        end else if (rx_strobe) begin
            rx_user_index <= next_rx_idx;
        end
    end

    // The parity slot is part of the struct, so any odd count of ones is an error.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_parity_err <= 1'b0;
        end else if (rx_strobe) begin
            rx_parity_err <= ^rx_sub;
        end
    end

    // Bits 5 to 15 are built locally; bits 0 to 4 and later bytes pass the received block through.
    always_comb begin
        if (next_tx_idx == 8'(UNLK_POS)) begin
            tx_c = next_unlocked[tx_chan];
        end else if (next_tx_idx >= 8'(SF_LSB) && next_tx_idx < 8'(SF_LSB + 2)) begin
            tx_c = tx_sample_freq[next_tx_idx[0]];
        end else if (next_tx_idx >= 8'(MODE_LSB) && next_tx_idx < 8'(FMT_LSB)) begin
            tx_c = tx_mode[next_tx_idx[1:0]];
        end else if (next_tx_idx >= 8'(FMT_LSB) && next_tx_idx < 8'(FMT_LSB + 4)) begin
            tx_c = tx_user_format[next_tx_idx[1:0]];
        end else begin
            tx_c = cs_held[tx_chan][next_tx_idx];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_out_strobe <= 1'b0;
            tx_out_z      <= 1'b0;
        end else begin
            tx_out_strobe <= tx_strobe;
            if (tx_strobe) begin
                tx_out_z <= !tx_chan && next_tx_idx == IDX_FIRST;
            end
        end
    end

    // Parity is taken over the very bits sent, so slots 4 to 31 always hold an even count.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_sub <= '0;
        end else begin
            if (tx_strobe) begin
                tx_sub.audio   <= tx_audio;
                tx_sub.v       <= tx_v;
                tx_sub.u       <= tx_u;
                tx_sub.c       <= tx_c;
                tx_sub.p       <= ^{tx_audio, tx_v, tx_u, tx_c};
            end
        end
    end

endmodule // csf_top
`default_nettype wire

// ### hdl/csf_pkg.sv
`default_nettype none
package csf_pkg;
    localparam int unsigned CS_BITS     = 192;
    localparam int unsigned CS_BYTES    = 24;
    localparam int unsigned NUM_CHAN    = 2;
    localparam int unsigned IDX_W       = 8;
    localparam logic [7:0]  IDX_LAST    = 8'h00_BF;
    localparam logic [7:0]  IDX_FIRST   = 8'h00_00;
    localparam int unsigned SF_LSB      = 6;
    localparam int unsigned UNLK_POS    = 5;
    localparam int unsigned MODE_LSB    = 8;
    localparam int unsigned FMT_LSB     = 12;
    localparam logic [191:0] CS_RST     = 192'h0;
    localparam logic        UNLK_RST    = 1'b1;
    localparam int unsigned CLK_MHZ     = 200;
    localparam int unsigned BLOCK_US    = 4000;
    localparam int unsigned BLOCK_CYC   = BLOCK_US * CLK_MHZ;
    localparam int unsigned STALE_W     = 20;

    typedef struct packed {
        logic [23:0] audio;
        logic        v;
        logic        u;
        logic        c;
        logic        p;
    } csf_sub_t;

    typedef struct packed {
        logic [1:0] sample_freq;
        logic       unlocked;
        logic [3:0] mode;
        logic [3:0] user_format;
    } csf_fields_t;
endpackage
`default_nettype wire

// ### test/csf_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module csf_assertions
    import csf_pkg::*;
(
    input wire logic       mclk,
    input wire logic       rst_b,
    input wire logic       policy_propagate,
    input wire logic       can_alter_flag,
    input wire logic       reference_source_generator,
    input wire logic       local_locked,
    input wire logic       aux_in_unlocked,
    input wire logic       rx_strobe,
    input wire logic       rx_chan,
    input wire logic       rx_z,
    input wire csf_sub_t   rx_sub,
    input wire logic       rx_out_strobe,
    input wire logic       rx_non_audio,
    input wire logic       rx_user_bit,
    input wire logic [7:0] rx_user_index,
    input wire logic       rx_parity_err,
    input wire logic [1:0] block_done,
    input wire logic       tx_out_strobe,
    input wire csf_sub_t   tx_sub,
    input wire logic [1:0] unlocked_out,
    input wire logic       operator_unsync
);
    // Flag relations are only judged once the delayed internal reset has surely ended.
    logic [2:0] up;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) up <= 3'h0;
        else if (up != 3'h4) up <= up + 3'h1;
    end
    wire logic rdy = (up == 3'h4);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_take; rx_strobe; endsequence
    sequence s_start; rx_strobe && !rx_chan && rx_z; endsequence
    property p_par; s_take |=> rx_out_strobe && rx_parity_err == ^$past(rx_sub); endproperty
    property p_user; s_take |=> rx_user_bit == $past(rx_sub.u); endproperty
    property p_valid; s_take |=> rx_non_audio == $past(rx_sub.v); endproperty
    property p_start; s_start |=> rx_user_index == 8'h00; endproperty
    property p_done; |block_done |-> rx_out_strobe && rx_user_index == 8'hBF; endproperty
    property p_txpar; tx_out_strobe |-> !(^tx_sub); endproperty
    property p_ref; rdy && reference_source_generator |=> unlocked_out == 2'b00; endproperty
    property p_own; rdy && !reference_source_generator && (can_alter_flag && !local_locked
        || aux_in_unlocked && (policy_propagate || !can_alter_flag)) |=> unlocked_out == 2'b11; endproperty
    property p_sync; rdy && !policy_propagate && !local_locked && !reference_source_generator |=> operator_unsync;
    endproperty
    a_par: assert property (p_par) else $error("parity flag wrong");
    a_user: assert property (p_user) else $error("user bit wrong");
    a_valid: assert property (p_valid) else $error("validity wrong");
    a_start: assert property (p_start) else $error("block start wrong");
    a_done: assert property (p_done) else $error("block end wrong");
    a_txpar: assert property (p_txpar) else $error("tx parity odd");
    a_ref: assert property (p_ref) else $error("reference flag set");
    a_own: assert property (p_own) else $error("unlock flag clear");
    a_sync: assert property (p_sync) else $error("no operator warning");
endmodule // csf_assertions
bind csf_top csf_assertions u_chk (.mclk, .rst_b, .policy_propagate, .can_alter_flag, .reference_source_generator,
    .local_locked, .aux_in_unlocked, .rx_strobe, .rx_chan, .rx_z, .rx_sub, .rx_out_strobe, .rx_non_audio,
    .rx_user_bit, .rx_user_index, .rx_parity_err, .block_done, .tx_out_strobe, .tx_sub, .unlocked_out,
    .operator_unsync);
`default_nettype wire

// ### test/csf_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module csf_far_end
    import csf_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         en,
    input  wire logic         corrupt,
    input  wire logic [191:0] cs0,
    input  wire logic [191:0] cs1,
    output logic              rx_strobe,
    output logic              rx_chan,
    output logic              rx_z,
    output csf_sub_t          rx_sub
);
    int       frame = 0;
    logic     ph = 1'b0;
    logic     nxt = 1'b0;
    csf_sub_t s;
    initial {rx_strobe, rx_chan, rx_z, rx_sub} = '0;
    // Between subframes the data lines toggle so a stale value can never pass as fresh.
    always @(posedge mclk) begin
        ph <= !ph;
        rx_strobe <= en && ph;
        if (en && ph) begin
            s = csf_sub_t'(28'($urandom));
            s.c = nxt ? cs1[frame] : cs0[frame];
            s.p = ^s[27:1] ^ corrupt;
            rx_sub <= s;
            rx_chan <= nxt;
            rx_z <= !nxt && frame == 0;
            if (nxt) frame = (frame + 1) % 192;
            nxt = !nxt;
        end else rx_sub <= ~rx_sub;
    end
endmodule // csf_far_end
`default_nettype wire

// ### test/csf_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module csf_top_bench;
    import csf_pkg::*;
    logic        mclk = 1'b0, rst_b = 1'b1, policy_propagate, can_alter_flag, reference_source_generator;
    logic        local_locked, aux_in_unlocked, rx_strobe, rx_chan, rx_z, tx_strobe, tx_chan, tx_z, tx_v, tx_u;
    logic        rd_chan, en, corrupt, rx_out_strobe, rx_out_chan, rx_non_audio, rx_user_bit, rx_parity_err;
    logic        tx_out_strobe, tx_out_z, operator_unsync;
    logic [23:0] tx_audio;
    logic [1:0]  tx_sample_freq, block_done, cs_stale, unlocked_out;
    logic [3:0]  tx_mode, tx_user_format;
    logic [4:0]  rd_byte;
    logic [7:0]  rd_data, rx_user_index;
    logic [25:0] pl;
    csf_sub_t    rx_sub, tx_sub;
    csf_fields_t [1:0] rx_fields;
    logic [191:0] cs0, cs1, mb[2], hb[2];
    int          err_count = 0, samples_checked = 0, idx[2] = '{191, 191}, nblk = 0;
    bit          pend = 1'b0;
    logic [11:0] q[$];
    csf_far_end u_far (.mclk, .en, .corrupt, .cs0, .cs1, .rx_strobe, .rx_chan, .rx_z, .rx_sub);
    csf_top #(.STALE_CYCLES(2000)) DUT (.mclk, .rst_b, .policy_propagate, .can_alter_flag, .reference_source_generator,
        .local_locked, .aux_in_unlocked, .rx_strobe, .rx_chan, .rx_z, .rx_sub, .tx_strobe, .tx_chan, .tx_z,
        .tx_audio, .tx_v, .tx_u, .tx_sample_freq, .tx_mode, .tx_user_format, .rd_chan, .rd_byte, .rd_data,
        .rx_fields, .block_done, .cs_stale, .rx_out_strobe, .rx_out_chan, .rx_non_audio, .rx_user_bit,
        .rx_user_index, .rx_parity_err, .tx_out_strobe, .tx_out_z, .tx_sub, .unlocked_out, .operator_unsync);
    task automatic check(input logic [191:0] seen, input logic [191:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic [1:0] flag_exp();
        logic [1:0] inc;
        inc = {hb[1][5], hb[0][5]};
        if (reference_source_generator) return 2'b00;
        if (!can_alter_flag) return inc | {2{aux_in_unlocked}};
        if (policy_propagate) return inc | {2{aux_in_unlocked | !local_locked}};
        return {2{!local_locked}};
    endfunction
    function automatic logic c_exp(int ch, int i);
        logic [191:0] b;
        logic [1:0]   f;
        f = flag_exp();
        b = hb[ch];
        b[15:5] = {tx_user_format, tx_mode, tx_sample_freq, f[ch]};
        return b[i];
    endfunction
    always @(posedge mclk) begin
        if (rx_out_strobe) check({rx_out_chan, rx_user_index, rx_non_audio, rx_user_bit, rx_parity_err},
            q.pop_front());
        for (int c = 0; c < 2; c++) if (block_done[c]) check(rx_fields[c], {hb[c][7:5], hb[c][11:8], hb[c][15:12]});
        nblk += block_done[1];
        if (rx_strobe) begin
            if (!rx_chan && rx_z) {idx[0], pend} = {32'd0, 1'b1};
            else if (rx_chan && pend) {idx[1], pend} = {32'd0, 1'b0};
            else idx[rx_chan] = (idx[rx_chan] + 1) % 192;
            mb[rx_chan][idx[rx_chan]] = rx_sub.c;
            if (idx[rx_chan] == 191) hb[rx_chan] = mb[rx_chan];
            q.push_back({rx_chan, 8'(idx[rx_chan]), rx_sub.v, rx_sub.u, ^rx_sub});
        end
    end
    initial forever #2.5 mclk = ~mclk;
    initial begin
        #(5 * 20000);
        err_count++;
        tally_and_finish();
    end
    initial begin
        rst_b <= 1'b0;
        void'($urandom(32'h06f0));
        {policy_propagate, can_alter_flag, reference_source_generator, local_locked, aux_in_unlocked} = 5'b11010;
        {tx_strobe, tx_chan, tx_z, tx_v, tx_u, rd_chan, en, corrupt, tx_audio, tx_sample_freq} = '0;
        {tx_mode, tx_user_format, rd_byte} = '0;
        cs0 = {6{$urandom}} & ~192'h20;
        cs1 = {6{$urandom}} | 192'h20;
        repeat (5) @(posedge mclk);
        check({unlocked_out, cs_stale}, 4'hF);
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        en <= 1'b1;
        for (int i = 0; i < 3000 && nblk < 2; i++) begin
            @(posedge mclk);
            corrupt <= ($urandom % 16) == 0;
        end
        en <= 1'b0;
        corrupt <= 1'b0;
        repeat (4) @(posedge mclk);
        check(cs_stale, 2'b00);
        repeat (2010) @(posedge mclk);
        check(cs_stale, 2'b11);
        $display("receive test done");
        for (int k = 0; k < 32; k++) begin
            @(posedge mclk);
            {policy_propagate, can_alter_flag, reference_source_generator, local_locked, aux_in_unlocked} <= 5'(k);
            repeat (3) @(posedge mclk);
            #1;
            check(unlocked_out, flag_exp());
            check(operator_unsync, !policy_propagate && !local_locked && !reference_source_generator);
        end
        $display("flag test done");
        @(posedge mclk);
        {policy_propagate, can_alter_flag, reference_source_generator, local_locked, aux_in_unlocked} <= 5'b11010;
        {tx_sample_freq, tx_mode, tx_user_format} <= 10'($urandom);
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            pl = 26'($urandom);
            {tx_strobe, tx_chan, tx_z, tx_audio, tx_v, tx_u} <= {1'b1, i[0], i == 0, pl};
            @(posedge mclk);
            tx_strobe <= 1'b0;
            #1;
            check({tx_out_strobe, tx_out_z, tx_sub.audio, tx_sub.v, tx_sub.u, tx_sub.c},
                {1'b1, i == 0, pl, c_exp(i % 2, i / 2)});
        end
        $display("transmit test done");
        for (int r = 0; r < 50; r++) begin
            @(posedge mclk);
            {rd_chan, rd_byte} <= {r[0], 5'(r >> 1)};
            @(posedge mclk);
            #1;
            check(rd_data, (r >> 1) < 24 ? hb[r % 2][8 * (r >> 1) +: 8] : 8'h00);
        end
        $display("read test done");
        tally_and_finish();
    end
endmodule // csf_top_bench
`default_nettype wire
